// >>> src/opd_pkg.sv
package opd_pkg;

    localparam int BYTE_W = 8;

    // Whole-opcode values
    localparam logic [7:0] OPC_SEG_LOAD      = 8'h8e;
    localparam logic [7:0] OPC_SEG_STORE     = 8'h8c;
    localparam logic [7:0] OPC_PTR_DS        = 8'hc5;
    localparam logic [7:0] OPC_PTR_ES        = 8'hc4;
    localparam logic [7:0] OPC_EA            = 8'h8d;
    localparam logic [7:0] OPC_FLAGS_TO_AH   = 8'h9f;
    localparam logic [7:0] OPC_AH_TO_FLAGS   = 8'h9e;
    localparam logic [7:0] OPC_TABLE_BYTE_TRANSLATE_TBL      = 8'hd7;
    localparam logic [7:0] OPC_ASC_ADD       = 8'h37;
    localparam logic [7:0] OPC_DEC_ADD       = 8'h27;
    localparam logic [7:0] OPC_ASC_SUB       = 8'h3f;
    localparam logic [7:0] OPC_DEC_SUB       = 8'h2f;
    localparam logic [7:0] OPC_ASC_MUL       = 8'hd4;
    localparam logic [7:0] OPC_ASC_DIV       = 8'hd5;
    localparam logic [7:0] ASC_SECOND        = 8'h0a;
    localparam logic [7:0] OPC_BYTE_EXT      = 8'h98;
    localparam logic [7:0] OPC_WORD_EXT      = 8'h99;

    // Six-bit prefixes of opcodes with two low flag bits
    localparam logic [5:0] PFX_ADD           = 6'h00;
    localparam logic [5:0] PFX_ADC           = 6'h04;
    localparam logic [5:0] PFX_SUB           = 6'h0a;
    localparam logic [5:0] PFX_SBB           = 6'h06;
    localparam logic [5:0] PFX_CMP           = 6'h0e;
    localparam logic [5:0] PFX_IMM_GRP       = 6'h20;
    localparam logic [5:0] PFX_SHIFT_GRP     = 6'h34;
    // Seven-bit prefix of the unary group
    localparam logic [6:0] PFX_UNARY_GRP     = 7'h7b;

    // Bit positions
    localparam int BIT_W     = 0;
    localparam int BIT_D     = 1;
    localparam int BIT_S     = 1;
    localparam int EXT_LSB   = 3;
    localparam int MOD_LSB   = 6;

    // Extension field codes
    localparam logic [2:0] EXT_000 = 3'h0;
    localparam logic [2:0] EXT_001 = 3'h1;
    localparam logic [2:0] EXT_010 = 3'h2;
    localparam logic [2:0] EXT_011 = 3'h3;
    localparam logic [2:0] EXT_100 = 3'h4;
    localparam logic [2:0] EXT_101 = 3'h5;
    localparam logic [2:0] EXT_110 = 3'h6;
    localparam logic [2:0] EXT_111 = 3'h7;

    typedef enum logic [5:0] {
        OP_NONE,
        OP_MOVE_TO_SEG,
        OP_MOVE_FROM_SEG,
        OP_LOAD_POINTER_DATA_SEGMENT,
        OP_LOAD_POINTER_EXTRA_SEGMENT,
        OP_LOAD_EFFECTIVE_ADDRESS,
        OP_FLAGS_TO_HIGH_ACCUMULATOR,
        OP_HIGH_ACCUMULATOR_TO_FLAGS,
        OP_TABLE_BYTE_TRANSLATE,
        OP_ADD,
        OP_ADD_WITH_CARRY,
        OP_SUBTRACT,
        OP_SUBTRACT_WITH_BORROW,
        OP_COMPARE_OP,
        OP_INVERT,
        OP_CHANGE_SIGN,
        OP_UNSIGNED_PRODUCT,
        OP_SIGNED_PRODUCT,
        OP_UNSIGNED_QUOTIENT,
        OP_SIGNED_QUOTIENT,
        OP_ASCII_ADD_ADJUST,
        OP_DECIMAL_ADD_ADJUST,
        OP_ASCII_SUBTRACT_ADJUST,
        OP_DECIMAL_SUBTRACT_ADJUST,
        OP_ASCII_PRODUCT_ADJUST,
        OP_ASCII_DIVIDE_ADJUST,
        OP_BYTE_TO_WORD_EXTEND,
        OP_WORD_TO_DOUBLEWORD_EXTEND,
        OP_ROTATE_LEFT,
        OP_ROTATE_RIGHT,
        OP_ROTATE_CARRY_LEFT,
        OP_SHIFT_LEFT,
        OP_LOGICAL_SHIFT_RIGHT,
        OP_ARITHMETIC_SHIFT_RIGHT,
        OP_ILLEGAL
    } opd_op_type;

    // What follows the opcode byte
    typedef enum logic [1:0] {
        FOL_NONE,
        FOL_MODRM,
        FOL_FIXED,
        FOL_MODRM_IMM
    } opd_follow_type;

endpackage

// >>> src/opd_classify.sv
`timescale 1ns/1ns
// Combinational classification of a first byte and its second byte
module opd_classify
    import opd_pkg::*;
(
    input  wire logic [7:0]     opc_i,
    input  wire logic [7:0]     modrm_i,
    output opd_op_type          op_o,
    output opd_follow_type      follow_o,
    output logic [1:0]          imm_len_o
);
    import opd_pkg::*;

    logic [2:0] ext;
    logic       w_bit;
    logic       s_bit;

    always_comb
    begin
        ext       = modrm_i[EXT_LSB +: 3];
        w_bit     = opc_i[BIT_W];
        s_bit     = opc_i[BIT_S];
        op_o      = OP_ILLEGAL;
        follow_o  = FOL_NONE;
        imm_len_o = 2'd0;
        unique case (opc_i)
            OPC_SEG_LOAD:    begin op_o = OP_MOVE_TO_SEG;    follow_o = FOL_MODRM; end // [RULE1]
            OPC_SEG_STORE:   begin op_o = OP_MOVE_FROM_SEG;  follow_o = FOL_MODRM; end // [RULE2]
            OPC_PTR_DS:
            begin
                op_o = OP_LOAD_POINTER_DATA_SEGMENT; // [RULE3]
                follow_o = FOL_MODRM;
            end
            OPC_PTR_ES:
            begin
                op_o = OP_LOAD_POINTER_EXTRA_SEGMENT; // [RULE3]
                follow_o = FOL_MODRM;
            end
            OPC_EA:          begin op_o = OP_LOAD_EFFECTIVE_ADDRESS; follow_o = FOL_MODRM; end // [RULE4]
            OPC_FLAGS_TO_AH: op_o = OP_FLAGS_TO_HIGH_ACCUMULATOR; // [RULE5]
            OPC_AH_TO_FLAGS: op_o = OP_HIGH_ACCUMULATOR_TO_FLAGS; // [RULE5]
            OPC_TABLE_BYTE_TRANSLATE_TBL:    op_o = OP_TABLE_BYTE_TRANSLATE; // [RULE6]
            OPC_ASC_ADD:     op_o = OP_ASCII_ADD_ADJUST; // [RULE11]
            OPC_DEC_ADD:     op_o = OP_DECIMAL_ADD_ADJUST; // [RULE11]
            OPC_ASC_SUB:     op_o = OP_ASCII_SUBTRACT_ADJUST; // [RULE12]
            OPC_DEC_SUB:     op_o = OP_DECIMAL_SUBTRACT_ADJUST; // [RULE12]
            OPC_ASC_MUL:
            begin
                follow_o = FOL_FIXED;
                op_o = (modrm_i == ASC_SECOND) ? OP_ASCII_PRODUCT_ADJUST : OP_ILLEGAL; // [RULE13]
            end
            OPC_ASC_DIV:
            begin
                follow_o = FOL_FIXED;
                op_o = (modrm_i == ASC_SECOND) ? OP_ASCII_DIVIDE_ADJUST : OP_ILLEGAL; // [RULE14]
            end
            OPC_BYTE_EXT:    op_o = OP_BYTE_TO_WORD_EXTEND; // [RULE15]
            OPC_WORD_EXT:    op_o = OP_WORD_TO_DOUBLEWORD_EXTEND; // [RULE16]
            default:
            begin
                follow_o = FOL_MODRM;
                unique case (opc_i[7:2])
                    PFX_ADD: op_o = OP_ADD; // [RULE7]
                    PFX_ADC: op_o = OP_ADD_WITH_CARRY; // [RULE7]
                    PFX_SUB: op_o = OP_SUBTRACT; // [RULE8]
                    PFX_SBB: op_o = OP_SUBTRACT_WITH_BORROW; // [RULE8]
                    PFX_CMP: op_o = OP_COMPARE_OP; // [RULE8]
                    PFX_IMM_GRP:
                    begin
                        follow_o = FOL_MODRM_IMM;
                        // Second data byte only for s clear and w set
                        imm_len_o = (!s_bit && w_bit) ? 2'd2 : 2'd1; // [RULE19] [RULE18]
                        unique case (ext) // [RULE9]
                            EXT_000: op_o = OP_ADD;
                            EXT_010: op_o = OP_ADD_WITH_CARRY;
                            EXT_011: op_o = OP_SUBTRACT_WITH_BORROW;
                            EXT_101: op_o = OP_SUBTRACT;
                            EXT_111: op_o = OP_COMPARE_OP;
                            default: op_o = OP_ILLEGAL;
                        endcase
                    end
                    PFX_SHIFT_GRP:
                    begin
                        unique case (ext) // [RULE17]
                            EXT_000: op_o = OP_ROTATE_LEFT;
                            EXT_001: op_o = OP_ROTATE_RIGHT;
                            EXT_010: op_o = OP_ROTATE_CARRY_LEFT;
                            EXT_100: op_o = OP_SHIFT_LEFT;
                            EXT_101: op_o = OP_LOGICAL_SHIFT_RIGHT;
                            EXT_111: op_o = OP_ARITHMETIC_SHIFT_RIGHT;
                            default: op_o = OP_ILLEGAL;
                        endcase
                    end
                    default:
                    begin
                        follow_o = FOL_NONE;
                        if (opc_i[7:1] == PFX_UNARY_GRP)
                        begin
                            follow_o = FOL_MODRM;
                            unique case (ext) // [RULE10]
                                EXT_010: op_o = OP_INVERT;
                                EXT_011: op_o = OP_CHANGE_SIGN;
                                EXT_100: op_o = OP_UNSIGNED_PRODUCT;
                                EXT_101: op_o = OP_SIGNED_PRODUCT;
                                EXT_110: op_o = OP_UNSIGNED_QUOTIENT;
                                EXT_111: op_o = OP_SIGNED_QUOTIENT;
                                default: op_o = OP_ILLEGAL;
                            endcase
                        end
                    end
                endcase
            end
        endcase
    end

endmodule // opd_classify

// >>> src/opd_decoder.sv
`timescale 1ns/1ns
// How it works
// RULE1: 10001110 plus operand byte moves an operand into a segment register.
// RULE2: 10001100 plus operand byte moves a segment register to register or memory.
// RULE3: 11000101 loads far pointer with data segment; 11000100 with extra segment.
// RULE4: 10001101 plus operand byte loads the effective address itself.
// RULE5: 10011111 copies flags to high accumulator; 10011110 stores it to flags.
// RULE6: 11010111 replaces low accumulator with the byte it indexes in a table.
// RULE7: 000100dw is add with carry, 000000dw plain add, both with operand byte.
// RULE8: 001010dw subtract, 000110dw subtract with borrow, 001110dw compare.
// RULE9: 100000sw picks immediate add, adc, sbb, sub or compare by extension field.
// RULE10: 1111011w picks invert, sign change, multiplies or divides by extension field.
// RULE11: 00110111 ascii add adjust; 00100111 decimal add adjust.
// RULE12: 00111111 ascii subtract adjust; 00101111 decimal subtract adjust.
// RULE13: 11010100 then 00001010 is ascii adjust after multiply.
// RULE14: 11010101 then 00001010 is ascii adjust before divide.
// RULE15: 10011000 sign-extends low accumulator byte to a word.
// RULE16: 10011001 sign-extends accumulator into accumulator and data pair.
// RULE17: 110100vw picks rotate or shift kind by extension field.
// RULE18: Bit 0 is width, bit 1 direction; sign-extend widens one immediate byte.
// RULE19: One immediate byte for byte ops, two for word unless sign-extended.
module opd_decoder
    import opd_pkg::*;
(
    input  wire logic                clk_sys_i,
    input  wire logic                rst_b_i,
    input  wire logic [7:0]          q_byte_i,
    input  wire logic                q_valid_i,
    output logic                     q_ready_o,
    input  wire logic                ex_ready_i,
    output logic                     ex_valid_o,
    output opd_op_type               ex_op_o,
    output logic [7:0]               ex_opcode_o,
    output logic                     ex_has_modrm_o,
    output logic [1:0]               ex_mod_o,
    output logic [2:0]               ex_reg_o,
    output logic [2:0]               ex_rm_o,
    output logic                     ex_word_o,
    output logic                     ex_reg_is_dest_o,
    output logic                     ex_sign_ext_o,
    output logic [15:0]              ex_imm_o
);
    import opd_pkg::*;

    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_SECOND,
        ST_IMM_LO,
        ST_IMM_HI,
        ST_ISSUE
    } opd_state_type;

    opd_state_type  state_q, state_d;
    logic [7:0]     opc_q, opc_d;
    logic [7:0]     sec_q, sec_d;
    logic [7:0]     imm_lo_q, imm_lo_d;
    logic [7:0]     imm_hi_q, imm_hi_d;
    logic           q_ready_q, q_ready_d;
    logic           ex_valid_q, ex_valid_d;
    opd_op_type     ex_op_q, ex_op_d;
    logic [7:0]     ex_opcode_q, ex_opcode_d;
    logic           ex_modrm_q, ex_modrm_d;
    logic [7:0]     ex_sec_q, ex_sec_d;
    logic           ex_word_q, ex_word_d;
    logic           ex_dir_q, ex_dir_d;
    logic           ex_sx_q, ex_sx_d;
    logic [15:0]    ex_imm_q, ex_imm_d;

    opd_op_type     cls_op;
    opd_follow_type cls_follow;
    logic [1:0]     cls_imm_len;
    opd_follow_type first_follow;
    logic           take;

    // Classify the held opcode against the second byte
    opd_classify u_classify
    (
        .opc_i     (opc_q),
        .modrm_i   ((state_q == ST_SECOND) ? q_byte_i : sec_q),
        .op_o      (cls_op),
        .follow_o  (cls_follow),
        .imm_len_o (cls_imm_len)
    );

    // Follow kind for a fresh opcode byte, ignoring its second byte
    opd_classify u_first
    (
        .opc_i     (q_byte_i),
        .modrm_i   (8'h00),
        .op_o      (),
        .follow_o  (first_follow),
        .imm_len_o ()
    );

    always_comb
    begin
        take        = q_valid_i && q_ready_q;
        state_d     = state_q;
        opc_d       = opc_q;
        sec_d       = sec_q;
        imm_lo_d    = imm_lo_q;
        imm_hi_d    = imm_hi_q;
        ex_valid_d  = ex_valid_q;
        ex_op_d     = ex_op_q;
        ex_opcode_d = ex_opcode_q;
        ex_modrm_d  = ex_modrm_q;
        ex_sec_d    = ex_sec_q;
        ex_word_d   = ex_word_q;
        ex_dir_d    = ex_dir_q;
        ex_sx_d     = ex_sx_q;
        ex_imm_d    = ex_imm_q;
        if (ex_valid_q && ex_ready_i)
        begin
            ex_valid_d = 1'b0;
        end
        unique case (state_q)
            ST_OPCODE:
            begin
                if (take)
                begin
                    opc_d    = q_byte_i;
                    sec_d    = 8'h00;
                    imm_lo_d = 8'h00;
                    imm_hi_d = 8'h00;
                    state_d  = (first_follow == FOL_NONE) ? ST_ISSUE : ST_SECOND;
                end
            end
            ST_SECOND:
            begin
                if (take)
                begin
                    sec_d   = q_byte_i;
                    state_d = (cls_follow == FOL_MODRM_IMM) ? ST_IMM_LO : ST_ISSUE;
                end
            end
            ST_IMM_LO:
            begin
                if (take)
                begin
                    imm_lo_d = q_byte_i;
                    state_d  = (cls_imm_len == 2'd2) ? ST_IMM_HI : ST_ISSUE; // [RULE19]
                end
            end
            ST_IMM_HI:
            begin
                if (take)
                begin
                    imm_hi_d = q_byte_i;
                    state_d  = ST_ISSUE;
                end
            end
            ST_ISSUE:
            begin
                if (!ex_valid_q || ex_ready_i)
                begin
                    ex_valid_d  = 1'b1;
                    ex_op_d     = cls_op;
                    ex_opcode_d = opc_q;
                    ex_modrm_d  = (cls_follow == FOL_MODRM) || (cls_follow == FOL_MODRM_IMM);
                    ex_sec_d    = sec_q;
                    ex_word_d   = opc_q[BIT_W]; // [RULE18]
                    ex_dir_d    = opc_q[BIT_D]; // [RULE18]
                    ex_sx_d     = (cls_follow == FOL_MODRM_IMM) && opc_q[BIT_S];
                    if (cls_imm_len == 2'd2)
                    begin
                        ex_imm_d = {imm_hi_q, imm_lo_q};
                    end
                    else if (ex_sx_d && opc_q[BIT_W])
                    begin
                        ex_imm_d = {{8{imm_lo_q[7]}}, imm_lo_q}; // [RULE18]
                    end
                    else
                    begin
                        ex_imm_d = {8'h00, imm_lo_q};
                    end
                    state_d = ST_OPCODE;
                end
            end
            default: state_d = ST_OPCODE;
        endcase
        // Accept queue bytes only while collecting
        q_ready_d = (state_d != ST_ISSUE);
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_q     <= ST_OPCODE;
            opc_q       <= 8'h00;
            sec_q       <= 8'h00;
            imm_lo_q    <= 8'h00;
            imm_hi_q    <= 8'h00;
            q_ready_q   <= 1'b0;
            ex_valid_q  <= 1'b0;
            ex_op_q     <= OP_NONE;
            ex_opcode_q <= 8'h00;
            ex_modrm_q  <= 1'b0;
            ex_sec_q    <= 8'h00;
            ex_word_q   <= 1'b0;
            ex_dir_q    <= 1'b0;
            ex_sx_q     <= 1'b0;
            ex_imm_q    <= 16'h0000;
        end
        else
        begin
            state_q     <= state_d;
            opc_q       <= opc_d;
            sec_q       <= sec_d;
            imm_lo_q    <= imm_lo_d;
            imm_hi_q    <= imm_hi_d;
            q_ready_q   <= q_ready_d;
            ex_valid_q  <= ex_valid_d;
            ex_op_q     <= ex_op_d;
            ex_opcode_q <= ex_opcode_d;
            ex_modrm_q  <= ex_modrm_d;
            ex_sec_q    <= ex_sec_d;
            ex_word_q   <= ex_word_d;
            ex_dir_q    <= ex_dir_d;
            ex_sx_q     <= ex_sx_d;
            ex_imm_q    <= ex_imm_d;
        end
    end

    assign q_ready_o        = q_ready_q;
    assign ex_valid_o       = ex_valid_q;
    assign ex_op_o          = ex_op_q;
    assign ex_opcode_o      = ex_opcode_q;
    assign ex_has_modrm_o   = ex_modrm_q;
    assign ex_mod_o         = ex_sec_q[MOD_LSB +: 2];
    assign ex_reg_o         = ex_sec_q[EXT_LSB +: 3];
    assign ex_rm_o          = ex_sec_q[2:0];
    assign ex_word_o        = ex_word_q;
    assign ex_reg_is_dest_o = ex_dir_q;
    assign ex_sign_ext_o    = ex_sx_q;
    assign ex_imm_o         = ex_imm_q;

endmodule // opd_decoder

// >>> tb/opd_queue_model.sv
`timescale 1ns/1ns
// Instruction byte queue feeding the decoder
module opd_queue_model
(
    input  wire logic       clk_sys_i,
    input  wire logic       rst_b_i,
    input  wire logic       push_i,
    input  wire logic [7:0] push_byte_i,
    input  wire logic       q_ready_i,
    output logic [7:0]      q_byte_o,
    output logic            q_valid_o
);
    logic [7:0] mem_q [16];
    logic [3:0] wr_q;
    logic [3:0] rd_q;
    logic [7:0] last_q;

    // Empty queue shows the inverse of the last byte
    assign q_valid_o = (wr_q != rd_q);
    assign q_byte_o  = q_valid_o ? mem_q[rd_q] : ~last_q;

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_q   <= 4'h0;
            rd_q   <= 4'h0;
            last_q <= 8'h00;
        end
        else
        begin
            if (push_i)
            begin
                mem_q[wr_q] <= push_byte_i;
                wr_q        <= wr_q + 4'h1;
            end
            if (q_valid_o && q_ready_i)
            begin
                rd_q   <= rd_q + 4'h1;
                last_q <= q_byte_o;
            end
        end
    end
endmodule // opd_queue_model

// >>> tb/opd_decoder_chk.sv
`timescale 1ns/1ns
module opd_decoder_chk
    import opd_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        rst_b_i,
    input wire logic        q_ready_o,
    input wire logic        ex_ready_i,
    input wire logic        ex_valid_o,
    input wire opd_op_type  ex_op_o,
    input wire logic [7:0]  ex_opcode_o,
    input wire logic        ex_has_modrm_o,
    input wire logic [2:0]  ex_reg_o,
    input wire logic        ex_word_o,
    input wire logic        ex_reg_is_dest_o,
    input wire logic        ex_sign_ext_o,
    input wire logic [15:0] ex_imm_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    // Group op by extension field, else OP_NONE
    function automatic opd_op_type grp_op(logic [7:0] o, logic [2:0] r);
        opd_op_type t [8];
        t = '{default: OP_NONE};
        if (o[7:2] == 6'h20)
            t = '{OP_ADD, OP_NONE, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW,
                  OP_NONE, OP_SUBTRACT, OP_NONE, OP_COMPARE_OP};
        if (o[7:1] == 7'h7b)
            t = '{OP_NONE, OP_NONE, OP_INVERT, OP_CHANGE_SIGN, OP_UNSIGNED_PRODUCT,
                  OP_SIGNED_PRODUCT, OP_UNSIGNED_QUOTIENT, OP_SIGNED_QUOTIENT};
        if (o[7:2] == 6'h34)
            t = '{OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_ROTATE_CARRY_LEFT, OP_NONE,
                  OP_SHIFT_LEFT, OP_LOGICAL_SHIFT_RIGHT, OP_NONE, OP_ARITHMETIC_SHIFT_RIGHT};
        return t[r];
    endfunction

    sequence s_issue;
        $fell(q_ready_o) && !ex_valid_o;
    endsequence
    sequence s_out;
        ex_valid_o && ex_op_o != OP_NONE;
    endsequence

    a_issue_next: assert property (s_issue |=> s_out)
        else $error("op late after issue");
    a_held_op: assert property (
        ex_valid_o && !ex_ready_i |=> ex_valid_o && $stable({ex_op_o, ex_imm_o}))
        else $error("pending op changed");
    a_seg_move: assert property (
        ex_valid_o && ex_opcode_o == 8'h8e |-> ex_op_o == OP_MOVE_TO_SEG && ex_has_modrm_o)
        else $error("segment load wrong");
    a_flag_copy: assert property (
        ex_valid_o && ex_opcode_o == 8'h9f |-> ex_op_o == OP_FLAGS_TO_HIGH_ACCUMULATOR)
        else $error("flag copy wrong");
    a_borrow_form: assert property (
        ex_valid_o && ex_opcode_o[7:2] == 6'h06 |-> ex_op_o == OP_SUBTRACT_WITH_BORROW)
        else $error("borrow form wrong");
    a_group_ext: assert property (
        ex_valid_o && grp_op(ex_opcode_o, ex_reg_o) != OP_NONE
        |-> ex_op_o == grp_op(ex_opcode_o, ex_reg_o))
        else $error("group op wrong");
    a_word_dir: assert property (
        ex_valid_o |-> ex_word_o == ex_opcode_o[0] && ex_reg_is_dest_o == ex_opcode_o[1])
        else $error("width or direction bit wrong");
    a_imm_sext: assert property (
        ex_valid_o && ex_opcode_o[7:2] == 6'h20 && ex_op_o != OP_ILLEGAL
        |-> ex_sign_ext_o == ex_opcode_o[1]
            && (ex_opcode_o[1:0] != 2'h3 || ex_imm_o[15:8] == {8{ex_imm_o[7]}}))
        else $error("sign extension of immediate wrong");
    a_byte_imm: assert property (
        ex_valid_o && ex_opcode_o[7:2] == 6'h20 && !ex_opcode_o[0]
        && ex_op_o != OP_ILLEGAL |-> ex_imm_o[15:8] == 8'h00)
        else $error("byte immediate has a high byte");
endmodule // opd_decoder_chk

bind opd_decoder opd_decoder_chk u_chk (.*);

// >>> tb/opd_decoder_tb.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module opd_decoder_tb;
    import opd_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_b_i, push_i, q_valid_i, q_ready_o, ex_ready_i, ex_valid_o, ex_has_modrm_o;
    logic ex_word_o, ex_reg_is_dest_o, ex_sign_ext_o;
    logic [7:0] push_byte_i, q_byte_i, ex_opcode_o;
    logic [1:0] ex_mod_o;
    logic [2:0] ex_reg_o, ex_rm_o;
    logic [15:0] ex_imm_o;
    opd_op_type ex_op_o;
    int num_errors = 0;
    int n_tests = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    opd_queue_model u_q (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .push_i(push_i),
        .push_byte_i(push_byte_i), .q_ready_i(q_ready_o), .q_byte_o(q_byte_i),
        .q_valid_o(q_valid_i));
    opd_decoder uut (.*);

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic sendb(input logic [7:0] b);
        @(posedge clk_sys_i);
        push_i      <= 1'b1;
        push_byte_i <= b;
    endtask

    task automatic sendv(input logic [7:0] b [$]);
        foreach (b[i]) sendb(b[i]);
    endtask

    // m[0] checks imm, m[1] checks reg; takes the op after checking
    task automatic exp_op(input opd_op_type op, input logic [2:0] rg,
                          input logic [15:0] imm, input logic [1:0] m);
        int k;
        @(posedge clk_sys_i);
        push_i <= 1'b0;
        k = 0;
        do
        begin
            @(negedge clk_sys_i);
            k++;
        end
        while (ex_valid_o !== 1'b1 && k < 40);
        `CHK("ex_valid_o", 1'b1, ex_valid_o)
        `CHK("ex_op_o", op, ex_op_o)
        if (m[0])
            `CHK("ex_imm_o", imm, ex_imm_o)
        if (m[1])
            `CHK("ex_reg_o", rg, ex_reg_o)
        @(posedge clk_sys_i);
        ex_ready_i <= 1'b1;
        @(posedge clk_sys_i);
        ex_ready_i <= 1'b0;
    endtask

    task automatic t_whole();
        logic [7:0] opc [9] = '{8'h9f, 8'h9e, 8'hd7, 8'h37, 8'h27, 8'h3f, 8'h2f, 8'h98, 8'h99};
        opd_op_type op [9] = '{OP_FLAGS_TO_HIGH_ACCUMULATOR, OP_HIGH_ACCUMULATOR_TO_FLAGS,
            OP_TABLE_BYTE_TRANSLATE, OP_ASCII_ADD_ADJUST, OP_DECIMAL_ADD_ADJUST,
            OP_ASCII_SUBTRACT_ADJUST, OP_DECIMAL_SUBTRACT_ADJUST, OP_BYTE_TO_WORD_EXTEND,
            OP_WORD_TO_DOUBLEWORD_EXTEND};
        foreach (opc[i]) sendb(opc[i]);
        foreach (opc[i]) exp_op(op[i], 3'h0, 16'h0000, 2'h0);
        $display("t_whole done");
    endtask

    task automatic t_modrm();
        logic [7:0] opc [5] = '{8'h8e, 8'h8c, 8'hc5, 8'hc4, 8'h8d};
        logic [7:0] mrm [5] = '{8'h1e, 8'hd8, 8'h07, 8'h0f, 8'h46};
        opd_op_type op [5] = '{OP_MOVE_TO_SEG, OP_MOVE_FROM_SEG,
            OP_LOAD_POINTER_DATA_SEGMENT, OP_LOAD_POINTER_EXTRA_SEGMENT,
            OP_LOAD_EFFECTIVE_ADDRESS};
        foreach (opc[i])
        begin
            sendb(opc[i]);
            sendb(mrm[i]);
        end
        foreach (opc[i]) exp_op(op[i], mrm[i][5:3], 16'h0000, 2'h2);
        $display("t_modrm done");
    endtask

    task automatic t_alu();
        logic [7:0] opc [5] = '{8'h00, 8'h13, 8'h2a, 8'h19, 8'h3b};
        opd_op_type op [5] = '{OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT,
            OP_SUBTRACT_WITH_BORROW, OP_COMPARE_OP};
        foreach (opc[i])
        begin
            sendb(opc[i]);
            sendb(8'hc8);
        end
        foreach (opc[i]) exp_op(op[i], 3'h1, 16'h0000, 2'h2);
        $display("t_alu done");
    endtask

    task automatic t_imm();
        logic [2:0] ext [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h7};
        opd_op_type op [5] = '{OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW,
            OP_SUBTRACT, OP_COMPARE_OP};
        foreach (ext[i])
        begin
            sendb(8'h81);
            sendb({2'h3, ext[i], 3'h0});
            sendb(8'h34);
            sendb(8'h12);
            exp_op(op[i], ext[i], 16'h1234, 2'h3);
        end
        sendv('{8'h83, 8'hc0, 8'h80, 8'h80, 8'hf8, 8'h7f, 8'h82, 8'hd0, 8'h85, 8'h98});
        exp_op(OP_ADD, 3'h0, 16'hff80, 2'h3);
        exp_op(OP_COMPARE_OP, 3'h7, 16'h007f, 2'h3);
        exp_op(OP_ADD_WITH_CARRY, 3'h2, 16'h0085, 2'h3);
        exp_op(OP_BYTE_TO_WORD_EXTEND, 3'h0, 16'h0000, 2'h0);
        $display("t_imm done");
    endtask

    task automatic t_unary();
        opd_op_type op [6] = '{OP_INVERT, OP_CHANGE_SIGN, OP_UNSIGNED_PRODUCT,
            OP_SIGNED_PRODUCT, OP_UNSIGNED_QUOTIENT, OP_SIGNED_QUOTIENT};
        foreach (op[i])
        begin
            sendb(8'hf7);
            sendb({2'h3, 3'(i + 2), 3'h1});
            exp_op(op[i], 3'(i + 2), 16'h0000, 2'h2);
        end
        sendv('{8'hf6, 8'hc1, 8'h99});
        exp_op(OP_ILLEGAL, 3'h0, 16'h0000, 2'h0);
        exp_op(OP_WORD_TO_DOUBLEWORD_EXTEND, 3'h0, 16'h0000, 2'h0);
        $display("t_unary done");
    endtask

    task automatic t_shift();
        logic [7:0] opc [6] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd2, 8'hd1};
        logic [2:0] ext [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
        opd_op_type op [6] = '{OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_ROTATE_CARRY_LEFT,
            OP_SHIFT_LEFT, OP_LOGICAL_SHIFT_RIGHT, OP_ARITHMETIC_SHIFT_RIGHT};
        foreach (opc[i])
        begin
            sendb(opc[i]);
            sendb({2'h1, ext[i], 3'h3});
        end
        foreach (opc[i]) exp_op(op[i], ext[i], 16'h0000, 2'h2);
        $display("t_shift done");
    endtask

    task automatic t_ascii();
        sendv('{8'hd4, 8'h0a, 8'hd5, 8'h0a, 8'hd4, 8'h0b, 8'h98});
        exp_op(OP_ASCII_PRODUCT_ADJUST, 3'h0, 16'h0000, 2'h0);
        exp_op(OP_ASCII_DIVIDE_ADJUST, 3'h0, 16'h0000, 2'h0);
        exp_op(OP_ILLEGAL, 3'h0, 16'h0000, 2'h0);
        exp_op(OP_BYTE_TO_WORD_EXTEND, 3'h0, 16'h0000, 2'h0);
        $display("t_ascii done");
    endtask

    // Output held while the queue runs dry mid-immediate
    task automatic t_stall();
        sendv('{8'h98, 8'h81, 8'hc0, 8'h34});
        @(posedge clk_sys_i);
        push_i <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        sendb(8'h12);
        @(posedge clk_sys_i);
        push_i <= 1'b0;
        repeat (10) @(negedge clk_sys_i);
        `CHK("ex_op_o", OP_BYTE_TO_WORD_EXTEND, ex_op_o)
        exp_op(OP_BYTE_TO_WORD_EXTEND, 3'h0, 16'h0000, 2'h0);
        exp_op(OP_ADD, 3'h0, 16'h1234, 2'h3);
        $display("t_stall done");
    endtask

    initial
    begin
        rst_b_i = 1'b0;
        push_i = 1'b0;
        push_byte_i = 8'h00;
        ex_ready_i = 1'b0;
        repeat (20) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        t_whole();
        t_modrm();
        t_alu();
        t_imm();
        t_unary();
        t_shift();
        t_ascii();
        t_stall();
        report_and_stop();
    end
endmodule // opd_decoder_tb
